/* inc/pmt_defs.svh */
// offsets, field positions, reset values and timing counts for the timer bank
// assumes: included by its bare name from the package and the design files
`ifndef PMT_DEFS_SVH
`define PMT_DEFS_SVH

// geometry
`define PMT_NUM_CH        6
`define PMT_CNT_W         16
`define PMT_ADDR_W        8

// register word offsets on the plain register port
`define PMT_OFF_START_LO  8'h00
`define PMT_OFF_START_HI  8'h01
`define PMT_OFF_IRQ_STAT  8'h02
`define PMT_OFF_IRQ_CLR   8'h03
`define PMT_OFF_IRQ_EN    8'h04
`define PMT_OFF_CH_BASE   8'h10
`define PMT_CH_STRIDE     2

// start bits sit at positions 5 to 7 of each count start register
`define PMT_START_LSB     5
`define PMT_START_PER_REG 3

// mode register field positions
`define PMT_MR_OP_LSB     0
`define PMT_MR_MSEL_LO    2
`define PMT_MR_MSEL_HI    3
`define PMT_MR_AUX        4
`define PMT_MR_OVF        5
`define PMT_MR_SRC_LSB    6

// reset values
`define PMT_MODE_RST      8'h00
`define PMT_CNT_RST       16'h0000
`define PMT_READ_RELOAD   16'hffff

// count source prescaler divisors in clock cycles
`define PMT_DIV_SRC0      1
`define PMT_DIV_SRC1      8
`define PMT_DIV_SRC2      32
`define PMT_DIV_SRC3      64
`define PMT_DIV_W         6

`endif

/* inc/pmt_pkg.sv */
// types shared by the timer bank files
// assumes: constants come from the defs header
`include "pmt_defs.svh"

package pmt_pkg;

  // operation mode of one channel
  typedef enum logic [1:0] {
    OP_TIMER   = 2'b00,
    OP_EVENT   = 2'b01,
    OP_MEASURE = 2'b10,
    OP_RSVD    = 2'b11
  } op_mode_type;

  // channel mode register, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0]  count_source_sel;
    logic        overflow_flag;
    logic        mode_aux_bit;
    logic        measure_select_hi;
    logic        measure_select_lo;
    op_mode_type operation_mode_sel;
  } mode_reg_type;

  // one register port request
  typedef struct packed {
    logic                     wr;
    logic                     rd;
    logic [`PMT_ADDR_W-1:0]   addr;
    logic [`PMT_CNT_W-1:0]    wdata;
  } bus_req_type;

endpackage : pmt_pkg

/* core/pmt_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
// assumes: inputs are asynchronous to i_mclk; reset is already synchronised
`timescale 1ns/100ps

module pmt_sync #(
  parameter int W = 1
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : pmt_sync

/* core/pmt_prescale.sv */
// free running prescaler giving the four internal count source ticks
// assumes: one clock; ticks 1-3 are single cycle pulses, tick 0 is high every cycle
`timescale 1ns/100ps
`include "pmt_defs.svh"

module pmt_prescale (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  output logic      [3:0] o_tick
);

  localparam logic [`PMT_DIV_W-1:0] DIV1 = `PMT_DIV_W'(`PMT_DIV_SRC1 - 1);
  localparam logic [`PMT_DIV_W-1:0] DIV2 = `PMT_DIV_W'(`PMT_DIV_SRC2 - 1);
  localparam logic [`PMT_DIV_W-1:0] DIV3 = `PMT_DIV_W'(`PMT_DIV_SRC3 - 1);

  logic [`PMT_DIV_W-1:0] div_q;

  // one shared counter; divisors are powers of two so masks pick the ticks
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q  <= '0;
      o_tick <= 4'h0;
    end else begin
      div_q  <= div_q + `PMT_DIV_W'(1);
      o_tick <= {(div_q & DIV3) == DIV3, (div_q & DIV2) == DIV2,
                 (div_q & DIV1) == DIV1, 1'b1};
    end
  end

endmodule : pmt_prescale

/* core/pmt_timer_bank.sv */
// bank of six 16-bit timer channels: timer, event counter, pulse measurement
// assumes: plain register port on i_mclk, pulse pins asynchronous
//
// Contract
// - channels idle after reset; count only while start bit is 1
// - start bits ch0-2 at bits 5-7 of low register, ch3-5 of high
// - counter read while counting returns live count in timer and event modes, capture in measurement; count continues
// - read coinciding with reload returns all ones
// - counter written while stopped reads back the written value
// - measurement: interrupt flag set on active edge and on overflow
// - overflow flag visible in mode register to find request cause
// - overflow clears only by write while running after a further tick
// - first edge after start captures undefined value, no interrupt
// - counter undefined at start; overflow may flag before first edge
// - width measurement continuous, no high or low level indication
`timescale 1ns/100ps
`include "pmt_defs.svh"

module pmt_timer_bank (
  input  wire logic                     i_mclk,
  input  wire logic                     i_reset_n,
  input  wire logic [`PMT_ADDR_W-1:0]   i_addr,
  input  wire logic [`PMT_CNT_W-1:0]    i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  input  wire logic [`PMT_NUM_CH-1:0]   i_pulse,
  output logic      [`PMT_CNT_W-1:0]    o_rdata,
  output logic                          o_irq
);

  localparam int NCH = `PMT_NUM_CH;
  localparam int CW  = `PMT_CNT_W;

  // reset release through two flip-flops
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // register port bundled as one request
  pmt_pkg::bus_req_type req;

  assign req.wr    = i_wr;
  assign req.rd    = i_rd;
  assign req.addr  = i_addr;
  assign req.wdata = i_wdata;

  // pins pass two flops before any logic looks at them
  logic [NCH-1:0] pulse_sync;

  pmt_sync #(
    .W (NCH)
  ) u_pulse_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_n_q),
    .i_async (i_pulse),
    .o_sync  (pulse_sync)
  );

  // internal count sources
  logic [3:0] src_tick;

  pmt_prescale u_prescale (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_n_q),
    .o_tick  (src_tick)
  );

  // global register decode
  wire wr_start_lo = req.wr && (req.addr == `PMT_OFF_START_LO);
  wire wr_start_hi = req.wr && (req.addr == `PMT_OFF_START_HI);
  wire wr_irq_clr  = req.wr && (req.addr == `PMT_OFF_IRQ_CLR);
  wire wr_irq_en   = req.wr && (req.addr == `PMT_OFF_IRQ_EN);

  logic [NCH-1:0] start_q;
  logic [NCH-1:0] ir_q;
  logic [NCH-1:0] ir_en_q;
  logic [NCH-1:0] ir_set;

  // start bits: channels 0-2 in low register, 3-5 in high register
  wire [2:0] start_lo_field = req.wdata[`PMT_START_LSB +: `PMT_START_PER_REG];
  wire [2:0] start_hi_field = req.wdata[`PMT_START_LSB +: `PMT_START_PER_REG];
  wire [NCH-1:0] start_d = {wr_start_hi ? start_hi_field : start_q[5:3],
                            wr_start_lo ? start_lo_field : start_q[2:0]};

  // clear mask only acts on bits that fire no set in the same cycle
  wire [NCH-1:0] clr_mask = wr_irq_clr ? req.wdata[NCH-1:0] : '0;
  wire [NCH-1:0] ir_d     = (ir_q & ~clr_mask) | ir_set;
  wire [NCH-1:0] ir_en_d  = wr_irq_en ? req.wdata[NCH-1:0] : ir_en_q;

  // start, status and enable registers
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      start_q <= '0;
      ir_q    <= '0;
      ir_en_q <= '0;
      o_irq   <= 1'b0;
    end else begin
      start_q <= start_d;
      ir_q    <= ir_d;
      ir_en_q <= ir_en_d;
      o_irq   <= |(ir_d & ir_en_d);
    end
  end

  // per channel read values for the read mux
  logic [7:0]    mode_rd [NCH];
  logic [CW-1:0] cnt_rd  [NCH];
  logic [NCH-1:0] hit_mode;
  logic [NCH-1:0] hit_cnt;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam logic [`PMT_ADDR_W-1:0] MODE_OFF =
      `PMT_ADDR_W'(`PMT_OFF_CH_BASE + `PMT_CH_STRIDE * i);
    localparam logic [`PMT_ADDR_W-1:0] CNT_OFF  =
      `PMT_ADDR_W'(`PMT_OFF_CH_BASE + `PMT_CH_STRIDE * i + 1);

    pmt_pkg::mode_reg_type cfg_q;
    pmt_pkg::mode_reg_type cfg_d;
    pmt_pkg::mode_reg_type wr_cfg;
    logic          ovf_q;
    logic          ovf_d;
    logic          tick_seen_q;
    logic          armed_q;
    logic          pin_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [CW-1:0] reload_q;
    logic [CW-1:0] reload_d;

    assign hit_mode[i] = (req.addr == MODE_OFF);
    assign hit_cnt[i]  = (req.addr == CNT_OFF);
    assign wr_cfg      = pmt_pkg::mode_reg_type'(req.wdata[7:0]);

    wire run      = start_q[i];
    wire mode_wr  = req.wr && hit_mode[i];
    wire cnt_wr   = req.wr && hit_cnt[i];
    wire is_meas  = (cfg_q.operation_mode_sel == pmt_pkg::OP_MEASURE);
    wire is_event = (cfg_q.operation_mode_sel == pmt_pkg::OP_EVENT);
    wire is_timer = (cfg_q.operation_mode_sel == pmt_pkg::OP_TIMER);
    wire tick     = src_tick[cfg_q.count_source_sel];

    // edge detect on the synchronised pin
    wire rise = pulse_sync[i] && !pin_q;
    wire fall = !pulse_sync[i] && pin_q;

    // event mode: measure_select_lo picks falling edge instead of rising
    wire ev_edge = cfg_q.measure_select_lo ? fall : rise;

    // measurement: 00 falling to falling, 01 rising to rising, else every edge
    wire both_edges = cfg_q.measure_select_hi;
    wire m_edge_raw = both_edges ? (rise || fall)
                    : (cfg_q.measure_select_lo ? rise : fall);

    // timer and event counting down
    wire dn_step   = run && ((is_timer && tick) || (is_event && ev_edge));
    wire underflow = dn_step && (cnt_q == '0);

    // measurement counting up from the source tick
    wire m_tick = run && is_meas && tick;
    wire m_edge = run && is_meas && m_edge_raw;
    wire m_ovf  = m_tick && !m_edge && (cnt_q == {CW{1'b1}});

    // reload moment for the read collision
    wire reload_now = underflow || m_edge;

    // flag clear needs a running channel and a tick after the flag rose
    wire ovf_clr = mode_wr && run && tick_seen_q && !wr_cfg.overflow_flag;

    // interrupt causes; the first capture after start is silent
    assign ir_set[i] = underflow || (m_edge && armed_q) || m_ovf;

    // mode fields only take a write while stopped; running writes only clear the flag
    always_comb begin
      cfg_d = cfg_q;
      if (mode_wr && !run) begin
        cfg_d = wr_cfg;
      end
      cfg_d.overflow_flag = 1'b0;
    end

    // overflow flag: a new overflow wins over a clear in the same cycle
    assign ovf_d = m_ovf ? 1'b1 : (ovf_clr ? 1'b0 : ovf_q);

    // counter next value
    always_comb begin
      cnt_d = cnt_q;
      if (cnt_wr && !run) begin
        cnt_d = req.wdata;
      end else if (underflow) begin
        cnt_d = reload_q;
      end else if (dn_step) begin
        cnt_d = cnt_q - CW'(1);
      end else if (m_edge) begin
        cnt_d = '0;
      end else if (m_tick) begin
        cnt_d = cnt_q + CW'(1); // wraps on overflow
      end
    end

    // reload holds the period in timer modes and the capture in measurement
    always_comb begin
      reload_d = reload_q;
      if (m_edge) begin
        reload_d = cnt_q;
      end else if (cnt_wr) begin
        reload_d = req.wdata;
      end
    end

    // channel state; the counter is not cleared at start
    always_ff @(posedge i_mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        cfg_q       <= pmt_pkg::mode_reg_type'(`PMT_MODE_RST);
        ovf_q       <= 1'b0;
        tick_seen_q <= 1'b0;
        armed_q     <= 1'b0;
        pin_q       <= 1'b0;
        cnt_q       <= `PMT_CNT_RST;
        reload_q    <= `PMT_CNT_RST;
      end else begin
        cfg_q       <= cfg_d;
        ovf_q       <= ovf_d;
        tick_seen_q <= m_ovf ? 1'b0 : (tick_seen_q || m_tick);
        armed_q     <= run && is_meas && (armed_q || m_edge);
        pin_q       <= pulse_sync[i];
        cnt_q       <= cnt_d;
        reload_q    <= reload_d;
      end
    end

    // readback: mode with live flag, counter or capture, all ones on reload
    assign mode_rd[i] = {cfg_q.count_source_sel, ovf_q, cfg_q.mode_aux_bit,
                         cfg_q.measure_select_hi, cfg_q.measure_select_lo,
                         cfg_q.operation_mode_sel};
    assign cnt_rd[i]  = reload_now ? `PMT_READ_RELOAD
                      : (is_meas ? reload_q : cnt_q);
  end

  // read mux; unmapped addresses and write-only registers read zero
  logic [CW-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    unique case (req.addr)
      `PMT_OFF_START_LO: rdata_d = CW'({start_q[2:0], 5'h00});
      `PMT_OFF_START_HI: rdata_d = CW'({start_q[5:3], 5'h00});
      `PMT_OFF_IRQ_STAT: rdata_d = CW'(ir_q);
      `PMT_OFF_IRQ_EN:   rdata_d = CW'(ir_en_q);
      default: begin
        for (int k = 0; k < NCH; k++) begin
          if (hit_mode[k]) begin
            rdata_d = CW'(mode_rd[k]);
          end
          if (hit_cnt[k]) begin
            rdata_d = cnt_rd[k];
          end
        end
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= req.rd ? rdata_d : '0;
    end
  end

endmodule : pmt_timer_bank

/* bench/pmt_timer_bank_asserts.sv */
// port checker for the timer bank: read data, start bits, irq gating
// assumes: bound to pmt_timer_bank, no two strobes at once
`timescale 1ns/100ps
`include "pmt_defs.svh"

module pmt_timer_bank_asserts (
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset_n,
  input  wire logic [`PMT_ADDR_W-1:0] i_addr,
  input  wire logic [`PMT_CNT_W-1:0]  i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire logic [`PMT_NUM_CH-1:0] i_pulse,
  input  wire logic [`PMT_CNT_W-1:0]  o_rdata,
  input  wire logic                   o_irq
);
  logic [5:0] en_q;
  logic [2:0] lo_q;
  logic [2:0] hi_q;

  // shadows of software-owned registers, updated as software writes them
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_q <= 6'h00;
      lo_q <= 3'h0;
      hi_q <= 3'h0;
    end else if (i_wr) begin
      if (i_addr == 8'h04) en_q <= i_wdata[5:0];
      if (i_addr == 8'h00) lo_q <= i_wdata[7:5];
      if (i_addr == 8'h01) hi_q <= i_wdata[7:5];
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  // read data stands only in the cycle after a read strobe
  property p_quiet; !$past(i_rd) |-> o_rdata == 16'h0000; endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside read cycle");
  property p_unmapped; i_rd && i_addr == 8'h08 |=> o_rdata == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_start_lo; i_rd && i_addr == 8'h00 |=> o_rdata[15:5] == {8'h00, lo_q}; endproperty
  a_start_lo: assert property (p_start_lo) else $error("low start bits wrong");
  property p_start_hi; i_rd && i_addr == 8'h01 |=> o_rdata[15:5] == {8'h00, hi_q}; endproperty
  a_start_hi: assert property (p_start_hi) else $error("high start bits wrong");
  property p_en_rd; i_rd && i_addr == 8'h04 |=> o_rdata == {10'h000, en_q}; endproperty
  a_en_rd: assert property (p_en_rd) else $error("enable readback wrong");
  // irq follows an enable write on the same edge, so no lag to allow for
  property p_irq_gate; en_q == 6'h00 |-> !o_irq; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq with all sources masked");
  property p_stat_w; i_rd && i_addr == 8'h02 |=> o_rdata[15:6] == 10'h000; endproperty
  a_stat_w: assert property (p_stat_w) else $error("status upper bits set");
  property p_mode_w; i_rd && i_addr == 8'h10 |=> o_rdata[15:8] == 8'h00; endproperty
  a_mode_w: assert property (p_mode_w) else $error("mode upper bits set");
  property p_hold;
    !lo_q[0] && i_rd && i_addr == 8'h11 ##1 i_rd && i_addr == 8'h11
      |=> o_rdata == $past(o_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped counter moved");
endmodule : pmt_timer_bank_asserts

bind pmt_timer_bank pmt_timer_bank_asserts i_pmt_timer_bank_asserts (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_pulse(i_pulse), .o_rdata(o_rdata), .o_irq(o_irq));

/* bench/pmt_pulse_src.sv */
// pulse pin source standing in for the measured signals and events
// assumes: one clock; enabled pins toggle together every i_half cycles
`timescale 1ns/100ps

module pmt_pulse_src (
  input  wire logic       i_mclk,
  input  wire logic [5:0] i_en,
  input  wire logic [7:0] i_half,
  output logic      [5:0] o_pulse
);
  logic [7:0] cnt_q;

  // shared phase counter; all pins rest low while none is enabled so each run starts on a rise
  always_ff @(posedge i_mclk) begin
    if (i_en == 6'h00) begin
      cnt_q   <= 8'h00;
      o_pulse <= 6'h00;
    end else if (cnt_q == i_half - 8'h01) begin
      cnt_q   <= 8'h00;
      o_pulse <= o_pulse ^ i_en;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : pmt_pulse_src

/* bench/pmt_timer_bank_tb.sv */
// self-checking bench driving the timer bank through its register port
// assumes: pulse source model on the pins, one 100 MHz clock
`timescale 1ns/100ps

module pmt_timer_bank_tb;
  logic        i_mclk    = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [7:0]  i_addr    = 8'h00;
  logic [15:0] i_wdata   = 16'h0000;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic [5:0]  pin_en    = 6'h00;
  logic [7:0]  half      = 8'h0a;
  logic [5:0]  i_pulse;
  logic [15:0] o_rdata;
  logic        o_irq;
  logic [15:0] v;
  logic [15:0] r [8];
  int          miscompares = 0;
  int          n_compared  = 0;
  int          cyc         = 0;
  int          hits;

  always #5 i_mclk = ~i_mclk;

  pmt_pulse_src i_pmt_pulse_src (.i_mclk(i_mclk), .i_en(pin_en), .i_half(half),
    .o_pulse(i_pulse));
  pmt_timer_bank i_pmt_timer_bank (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_pulse(i_pulse), .o_rdata(o_rdata),
    .o_irq(o_irq));

  task automatic print_verdict();
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] e);
    n_compared++;
    if (got !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, e);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  task automatic chk(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    cmp(v, e);
  endtask : chk

  // strobe held high: n back-to-back reads, results land in r
  task automatic burst(input logic [7:0] a, input int n);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    for (int k = 0; k < n; k++) begin
      @(posedge i_mclk);
      if (k == n - 1) i_rd <= 1'b0;
      #1 r[k] = o_rdata;
    end
  endtask : burst

  initial begin
    repeat (8) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    for (int c = 0; c < 6; c++) begin
      chk(8'h10 + 8'(2 * c), 16'h0000);
      chk(8'h11 + 8'(2 * c), 16'h0000);
    end
    chk(8'h00, 16'h0000);
    chk(8'h01, 16'h0000);
    chk(8'h02, 16'h0000);
    chk(8'h04, 16'h0000);
    for (int c = 0; c < 6; c++) begin
      wr(c < 3 ? 8'h00 : 8'h01, 16'h0020 << (c % 3));
      chk(c < 3 ? 8'h00 : 8'h01, 16'h0020 << (c % 3));
      wr(c < 3 ? 8'h00 : 8'h01, 16'h0000);
    end
    // ch0 timer at full rate, reload 5
    wr(8'h11, 16'h0005);
    chk(8'h11, 16'h0005);
    wr(8'h03, 16'h003f);
    wr(8'h04, 16'h0001);
    wr(8'h00, 16'h0020);
    burst(8'h11, 8);
    hits = 0;
    for (int k = 0; k < 8; k++) begin
      if (r[k] === 16'hffff) hits++;
      else if (k > 0 && r[k-1] !== 16'hffff) cmp(r[k], r[k-1] - 16'h0001);
    end
    cmp(16'(hits > 0), 16'h0001);
    for (int k = 0; k < 20 && o_irq !== 1'b1; k++) @(posedge i_mclk);
    #1 cmp({15'h0000, o_irq}, 16'h0001);
    chk(8'h02, 16'h0001);
    wr(8'h10, 16'h0001);
    chk(8'h10, 16'h0000);
    wr(8'h00, 16'h0000);
    burst(8'h11, 3);
    cmp(r[1], r[0]);
    cmp(r[2], r[0]);
    // mask then clear the sticky bit; status itself is read only
    wr(8'h04, 16'h0000);
    repeat (2) @(posedge i_mclk);
    #1 cmp({15'h0000, o_irq}, 16'h0000);
    wr(8'h02, 16'h003f);
    chk(8'h02, 16'h0001);
    wr(8'h03, 16'h0001);
    chk(8'h02, 16'h0000);
    chk(8'h08, 16'h0000);
    // ch1 width measurement on both edges, div 8, pin half period 20
    wr(8'h12, 16'h004a);
    wr(8'h04, 16'h0002);
    wr(8'h00, 16'h0040);
    half   <= 8'h14;
    pin_en <= 6'h02;
    repeat (30) @(posedge i_mclk);
    chk(8'h02, 16'h0000);
    repeat (20) @(posedge i_mclk);
    chk(8'h02, 16'h0002);
    rd(8'h13);
    cmp(16'(v >= 16'h0002 && v <= 16'h0003), 16'h0001);
    chk(8'h12, 16'h004a);
    wr(8'h03, 16'h0002);
    repeat (20) @(posedge i_mclk);
    chk(8'h02, 16'h0002);
    wr(8'h00, 16'h0000);
    // pins quiet from here so no edge can meet the overflow below
    pin_en <= 6'h00;
    // ch2 measurement from a preset near the top: overflow
    wr(8'h14, 16'h0002);
    wr(8'h15, 16'hfff0);
    wr(8'h03, 16'h003f);
    wr(8'h04, 16'h0004);
    wr(8'h00, 16'h0080);
    repeat (40) @(posedge i_mclk);
    // overflow found through the request flag first, cause read afterwards
    chk(8'h02, 16'h0004);
    chk(8'h14, 16'h0022);
    wr(8'h00, 16'h0000);
    wr(8'h14, 16'h0002);
    chk(8'h14, 16'h0022);
    wr(8'h00, 16'h0080);
    wr(8'h14, 16'h0002);
    chk(8'h14, 16'h0002);
    wr(8'h00, 16'h0000);
    // ch3 event counter on rising pin edges, reload 2
    wr(8'h16, 16'h0001);
    wr(8'h17, 16'h0002);
    wr(8'h03, 16'h003f);
    wr(8'h04, 16'h0008);
    wr(8'h01, 16'h0020);
    half   <= 8'h0a;
    pin_en <= 6'h08;
    repeat (40) @(posedge i_mclk);
    chk(8'h02, 16'h0000);
    repeat (20) @(posedge i_mclk);
    chk(8'h02, 16'h0008);
    cmp({15'h0000, o_irq}, 16'h0001);
    print_verdict();
  end
endmodule : pmt_timer_bank_tb
